// ### pss_pwm_shutdown.v
// Purpose: start-up and auto-shutdown control of a four-output pwm
// Assumes: apb slave on pclk, pins and comparators synchronous to pclk
// Notes:   outputs stay high-impedance until the drivers are enabled
//
// Function
// - polarity per pair A/C and B/D
// - period flag set as second period begins
// - pins high-impedance after reset
// - shutdown forces set state per pair: low, high or floated
// - three-bit source select at bits 6:4
// - fault low or comparators raise shutdown
// - firmware setting status bit forces shutdown
// - bit 7 reports shutdown state
//
// The implementer's own choices: the address map and register access over APB.
`default_nettype none
`include "pss_defines.vh"

module pss_pwm_shutdown (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clk_en,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        fault_input_n,
  input  wire        comparator_one,
  input  wire        comparator_two,
  output reg         pwm_output_a,
  output reg         pwm_output_b,
  output reg         pwm_output_c,
  output reg         pwm_output_d,
  output reg         pwm_output_a_oe,
  output reg         pwm_output_b_oe,
  output reg         pwm_output_c_oe,
  output reg         pwm_output_d_oe,
  output reg         time_base_one_period_flag,
  output reg         time_base_two_period_flag
);

  // shutdown pin state decode, shared by both pairs
  function pin_state;
    input [1:0] code;
    begin
      pin_state = (code == `PSS_PIN_HIGH);
    end
  endfunction

  // shutdown pin tristate decode: codes 2 and 3 float the pin
  function pin_float;
    input [1:0] code;
    begin
      pin_float = code[1];
    end
  endfunction

  reg  [7:0] module_control_reg;
  reg  [7:0] auto_shutdown_control;
  reg  [7:0] period_reg;
  reg  [7:0] duty_reg;
  reg        cycle_seen_reg;
  reg  [1:0] wrap_cnt_reg;
  wire [7:0] count;
  wire       wrap;
  wire       acc_wr;
  wire       acc_rd;
  wire [2:0] src_sel;
  wire [1:0] output_polarity_select;
  wire       pwm_en;
  wire       drv_en;
  wire       shdn_src_hit;
  wire       sw_set_ses;
  wire       sw_clr_ses;
  wire       shutdown_event_status;
  wire       raw_pwm;
  wire       addr_ok;
  wire [7:0] shdn_wdata;

  pss_time_base u_tb (
    .pclk      (pclk),
    .presetn   (presetn),
    .clk_en    (clk_en),
    .run       (pwm_en),
    .period    (period_reg),
    .count_reg (count),
    .wrap_reg  (wrap)
  );

  // apb phase decode; slave answers with zero wait states
  assign acc_wr  = psel & penable & pwrite & pready;
  assign acc_rd  = psel & penable & ~pwrite & pready;
  assign addr_ok = (paddr == `PSS_CTRL_ADDR) | (paddr == `PSS_SHDN_ADDR) |
                   (paddr == `PSS_FLAG_ADDR) | (paddr == `PSS_PERIOD_ADDR) |
                   (paddr == `PSS_DUTY_ADDR);

  // field extraction
  assign output_polarity_select =
    module_control_reg[`PSS_POL_MSB:`PSS_POL_LSB];
  assign pwm_en  = module_control_reg[`PSS_PWM_EN_BIT];
  assign drv_en  = module_control_reg[`PSS_DRV_EN_BIT];
  assign src_sel = auto_shutdown_control[`PSS_SS_MSB:`PSS_SS_LSB];
  assign shutdown_event_status = auto_shutdown_control[`PSS_SES_BIT];

  // enabled sources: bit 2 fault pin low, bit 0 cmp one, bit 1 cmp two
  assign shdn_src_hit = (src_sel[2] & ~fault_input_n) |
                        (src_sel[0] & comparator_one) |
                        (src_sel[1] & comparator_two);

  assign sw_set_ses = acc_wr & (paddr == `PSS_SHDN_ADDR) &
                      pwdata[`PSS_SES_BIT];
  assign sw_clr_ses = acc_wr & (paddr == `PSS_SHDN_ADDR) &
                      ~pwdata[`PSS_SES_BIT];

  // writable part of the shutdown register; status bit handled apart
  assign shdn_wdata = pwdata[7:0] & `PSS_SHDN_MASK;

  // apb handshake, ready pulsed for one cycle in the access phase, error on unmapped address
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~(paddr == `PSS_CTRL_ADDR |
                 paddr == `PSS_SHDN_ADDR | paddr == `PSS_FLAG_ADDR |
                 paddr == `PSS_PERIOD_ADDR | paddr == `PSS_DUTY_ADDR);
    end
  end

  // control registers written by software
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      module_control_reg <= `PSS_CTRL_RST;
      period_reg         <= `PSS_PERIOD_RST;
      duty_reg           <= `PSS_DUTY_RST;
    end else if (clk_en && acc_wr) begin
      if (paddr == `PSS_CTRL_ADDR)
        module_control_reg <= pwdata[7:0] & `PSS_CTRL_MASK;
      if (paddr == `PSS_PERIOD_ADDR)
        period_reg <= pwdata[7:0];
      if (paddr == `PSS_DUTY_ADDR)
        duty_reg <= pwdata[7:0];
    end
  end

  // shutdown control: event sets status, which holds until cleared
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_shutdown_control <= `PSS_SHDN_RST;
    end else if (clk_en) begin
      if (acc_wr && paddr == `PSS_SHDN_ADDR)
        auto_shutdown_control[6:0] <= shdn_wdata[6:0];
      if (shdn_src_hit | sw_set_ses)
        auto_shutdown_control[`PSS_SES_BIT] <= 1'b1;
      else if (sw_clr_ses)
        auto_shutdown_control[`PSS_SES_BIT] <= 1'b0;
    end
  end

  // period flags: a wrap sets only the flag picked by the time base select bit, the first as second period begins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cycle_seen_reg            <= 1'b0;
      wrap_cnt_reg              <= 2'h0;
      time_base_one_period_flag <= 1'b0;
      time_base_two_period_flag <= 1'b0;
    end else if (clk_en) begin
      if (!pwm_en)
        wrap_cnt_reg <= 2'h0;
      else if (wrap && wrap_cnt_reg != 2'h2)
        wrap_cnt_reg <= wrap_cnt_reg + 2'h1;
      cycle_seen_reg <= (wrap_cnt_reg == 2'h2);
      // hardware set wins over a software clear in the same cycle
      if (wrap && !module_control_reg[`PSS_TB_SEL_BIT])
        time_base_one_period_flag <= 1'b1;
      else if (acc_wr && paddr == `PSS_FLAG_ADDR && pwdata[0])
        time_base_one_period_flag <= 1'b0;
      if (wrap && module_control_reg[`PSS_TB_SEL_BIT])
        time_base_two_period_flag <= 1'b1;
      else if (acc_wr && paddr == `PSS_FLAG_ADDR && pwdata[1])
        time_base_two_period_flag <= 1'b0;
    end
  end

  assign raw_pwm = pwm_en & (count < duty_reg);

  // pin drive: floated after reset, forced state while shut down
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_output_a    <= 1'b0;
      pwm_output_b    <= 1'b0;
      pwm_output_c    <= 1'b0;
      pwm_output_d    <= 1'b0;
      pwm_output_a_oe <= 1'b0;
      pwm_output_b_oe <= 1'b0;
      pwm_output_c_oe <= 1'b0;
      pwm_output_d_oe <= 1'b0;
    end else if (clk_en) begin
      if (shutdown_event_status | shdn_src_hit | sw_set_ses) begin
        pwm_output_a <= pin_state(auto_shutdown_control[1:0]);
        pwm_output_c <= pin_state(auto_shutdown_control[1:0]);
        pwm_output_b <= pin_state(auto_shutdown_control[3:2]);
        pwm_output_d <= pin_state(auto_shutdown_control[3:2]);
        pwm_output_a_oe <= drv_en & ~pin_float(auto_shutdown_control[1:0]);
        pwm_output_c_oe <= drv_en & ~pin_float(auto_shutdown_control[1:0]);
        pwm_output_b_oe <= drv_en & ~pin_float(auto_shutdown_control[3:2]);
        pwm_output_d_oe <= drv_en & ~pin_float(auto_shutdown_control[3:2]);
      end else begin
        pwm_output_a <= raw_pwm ^ output_polarity_select[0];
        pwm_output_c <= raw_pwm ^ output_polarity_select[0];
        pwm_output_b <= ~raw_pwm ^ output_polarity_select[1];
        pwm_output_d <= ~raw_pwm ^ output_polarity_select[1];
        pwm_output_a_oe <= drv_en;
        pwm_output_b_oe <= drv_en;
        pwm_output_c_oe <= drv_en;
        pwm_output_d_oe <= drv_en;
      end
    end
  end

  // read data mux
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en) begin
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite && addr_ok) begin
        case (paddr)
          `PSS_CTRL_ADDR:   prdata[7:0] <= module_control_reg;
          `PSS_SHDN_ADDR:   prdata[7:0] <= auto_shutdown_control;
          `PSS_FLAG_ADDR:   prdata[2:0] <= {cycle_seen_reg,
                                            time_base_two_period_flag,
                                            time_base_one_period_flag};
          `PSS_PERIOD_ADDR: prdata[7:0] <= period_reg;
          `PSS_DUTY_ADDR:   prdata[7:0] <= duty_reg;
          default:          prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // pss_pwm_shutdown

`default_nettype wire

// ### pss_defines.vh
// Purpose: constants for the pwm start-up and auto-shutdown block
// Assumes: apb byte addresses, 32-bit data, 8-bit registers in low bits
// Notes:   header holds definitions only
`ifndef PSS_DEFINES_VH
`define PSS_DEFINES_VH

// register byte addresses
`define PSS_CTRL_ADDR    12'h000
`define PSS_SHDN_ADDR    12'h004
`define PSS_FLAG_ADDR    12'h008
`define PSS_PERIOD_ADDR  12'h00c
`define PSS_DUTY_ADDR    12'h010

// module_control_reg fields
`define PSS_POL_LSB      0
`define PSS_POL_MSB      1
`define PSS_PWM_EN_BIT   2
`define PSS_DRV_EN_BIT   3
`define PSS_TB_SEL_BIT   4
`define PSS_CTRL_MASK    8'h1f

// auto_shutdown_control fields
`define PSS_SS_MSB       6
`define PSS_SS_LSB       4
`define PSS_STATE_AC_LSB 0
`define PSS_STATE_BD_LSB 2
`define PSS_SES_BIT      7
`define PSS_SHDN_MASK    8'h7f

// source select encodings
`define PSS_SRC_NONE     3'h0
`define PSS_SRC_CMP1     3'h1
`define PSS_SRC_CMP2     3'h2
`define PSS_SRC_CMP12    3'h3
`define PSS_SRC_FLT      3'h4
`define PSS_SRC_FLT_C1   3'h5
`define PSS_SRC_FLT_C2   3'h6
`define PSS_SRC_ALL      3'h7

// shutdown pin states
`define PSS_PIN_LOW      2'h0
`define PSS_PIN_HIGH     2'h1

// reset values
`define PSS_CTRL_RST     8'h00
`define PSS_SHDN_RST     8'h00
`define PSS_PERIOD_RST   8'hff
`define PSS_DUTY_RST     8'h00

`endif

// ### pss_time_base.v
// Purpose: pwm time base, counter with period flag pulse
// Assumes: pclk domain, inputs synchronous
// Notes:   wrap pulse marks the start of every new period
`default_nettype none

module pss_time_base (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       clk_en,
  input  wire       run,
  input  wire [7:0] period,
  output reg  [7:0] count_reg,
  output reg        wrap_reg
);

  // counter runs 0..period and restarts, pulsing wrap on restart
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= 8'h00;
      wrap_reg  <= 1'b0;
    end else if (clk_en) begin
      wrap_reg <= 1'b0;
      if (!run) begin
        count_reg <= 8'h00;
      end else if (count_reg >= period) begin
        count_reg <= 8'h00;
        wrap_reg  <= 1'b1;
      end else begin
        count_reg <= count_reg + 8'h01;
      end
    end
  end

endmodule // pss_time_base

`default_nettype wire

// ### pss_power_stage.sv
// Purpose: external power switch stage driven by the four pwm pins
// Assumes: each pin has a pull-down that keeps its switch off
// Notes:   index 0..3 is pin a, b, c, d
`default_nettype none

module pss_power_stage (
  input  wire logic [3:0] pin,
  input  wire logic [3:0] oe,
  output var  logic [3:0] sw_on
);
  timeunit 1ns;
  timeprecision 1ps;
  // a floating pin is pulled low, so its switch stays off
  assign sw_on = pin & oe;
endmodule // pss_power_stage

`default_nettype wire

// ### pss_pwm_shutdown_checker.sv
// Purpose: port-level assertions for the pwm start-up and shutdown block
// Assumes: one pclk domain, clk_en held high by the bench
// Notes:   shutdown and driver settings are shadowed from apb writes
`default_nettype none
`include "pss_defines.vh"

module pss_pwm_shutdown_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        fault_input_n,
  input wire logic        comparator_one,
  input wire logic        comparator_two,
  input wire logic        pwm_output_a,
  input wire logic        pwm_output_b,
  input wire logic        pwm_output_a_oe,
  input wire logic        pwm_output_b_oe,
  input wire logic        pwm_output_c_oe,
  input wire logic        pwm_output_d_oe,
  input wire logic        time_base_one_period_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic       wr_ok;
  logic       hit;
  logic [6:0] shdn_q;
  logic       drv_q;

  // a write lands at the edge that sees pready; hit is a selected source
  assign wr_ok = psel && penable && pready && pwrite;
  assign hit = (shdn_q[4] && comparator_one) || (shdn_q[5] && comparator_two)
    || (shdn_q[6] && !fault_input_n);

  // shadow copies of the shutdown register and the driver enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shdn_q <= 7'h00;
      drv_q  <= 1'b0;
    end else if (wr_ok && paddr == `PSS_SHDN_ADDR) begin
      shdn_q <= pwdata[6:0];
    end else if (wr_ok && paddr == `PSS_CTRL_ADDR) begin
      drv_q <= pwdata[`PSS_DRV_EN_BIT];
    end
  end

  a_reset_float: assert property ($rose(presetn) |->
    {pwm_output_a_oe, pwm_output_b_oe, pwm_output_c_oe,
     pwm_output_d_oe} == 4'h0)
    else $error("pin drivers on straight after reset");
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no answer in the access phase");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  a_err_unmapped: assert property (pready |-> pslverr ==
    !(paddr == `PSS_CTRL_ADDR || paddr == `PSS_SHDN_ADDR ||
      paddr == `PSS_FLAG_ADDR || paddr == `PSS_PERIOD_ADDR ||
      paddr == `PSS_DUTY_ADDR))
    else $error("pslverr does not match the address map");
  a_rdata_clean: assert property (pready && !pwrite |->
    prdata[31:8] == 24'h0 && (!pslverr || prdata == 32'h0))
    else $error("read data has bits beyond the register");
  a_oe_pairs: assert property (
    pwm_output_a_oe == pwm_output_c_oe && pwm_output_b_oe == pwm_output_d_oe)
    else $error("pair members disagree on driving");
  a_flag_sticky: assert property (time_base_one_period_flag &&
    !(wr_ok && paddr == `PSS_FLAG_ADDR && pwdata[0]) |=>
    time_base_one_period_flag)
    else $error("period flag dropped without a clear");
  a_shdn_force: assert property (hit |=>
    pwm_output_a_oe == (drv_q && !shdn_q[1]) && (!pwm_output_a_oe ||
    pwm_output_a == shdn_q[0]) && pwm_output_b_oe == (drv_q && !shdn_q[3])
    && (!pwm_output_b_oe || pwm_output_b == shdn_q[2]))
    else $error("pins not in the shutdown state");
endmodule // pss_pwm_shutdown_checker

bind pss_pwm_shutdown pss_pwm_shutdown_checker u_pss_chk (.*);

`default_nettype wire

// ### tb_pwm_startup_auto_shutdown.sv
// Purpose: register-level test of start-up order and auto-shutdown
// Assumes: duty 0 leaves pins a and c at their inactive level, b and d at their active level
// Notes:   pin index 0..3 is a, b, c, d
`default_nettype none
`include "pss_defines.vh"

module tb_pwm_startup_auto_shutdown;
  timeunit 1ns;
  timeprecision 1ps;
  logic             pclk = 1'b0;
  logic             presetn = 1'b0;
  logic             psel = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite = 1'b0;
  logic      [11:0] paddr = 12'h000;
  logic      [31:0] pwdata = 32'h0;
  logic             clk_en = 1'b1;
  logic             fault_n = 1'b1;
  logic             cmp1 = 1'b0;
  logic             cmp2 = 1'b0;
  logic      [31:0] prdata;
  logic             pready;
  logic             pslverr;
  logic             flag1;
  logic             flag2;
  wire logic [3:0]  pin;
  wire logic [3:0]  oe;
  wire logic [3:0]  sw;
  logic      [31:0] rdat;
  int               n_fail = 0;
  int               checked = 0;
  int               i;

  pss_pwm_shutdown DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fault_input_n(fault_n), .comparator_one(cmp1), .comparator_two(cmp2),
    .pwm_output_a(pin[0]), .pwm_output_b(pin[1]), .pwm_output_c(pin[2]),
    .pwm_output_d(pin[3]), .pwm_output_a_oe(oe[0]), .pwm_output_b_oe(oe[1]),
    .pwm_output_c_oe(oe[2]), .pwm_output_d_oe(oe[3]),
    .time_base_one_period_flag(flag1), .time_base_two_period_flag(flag2));
  pss_power_stage u_stage (.pin(pin), .oe(oe), .sw_on(sw));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string what);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // one apb transfer; read data and pslverr land in rdat
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge pclk);
    rdat = pslverr === 1'b1 ? 32'h100 | prdata : prdata;
    {psel, penable} <= 2'b00;
    if (n == 20) begin
      n_fail++;
      stop_test();
    end
  endtask

  // drive the sources: bit 0 comparator one, 1 comparator two, 2 fault
  task automatic src(input logic [2:0] v);
    @(posedge pclk);
    {fault_n, cmp2, cmp1} <= v ^ 3'b100;
  endtask

  // poll the flag register until a bit sets, bounded
  task automatic wait_bit(input int b);
    int k;
    for (k = 0; k < 200 && rdat[b] !== 1'b1; k++) apb(0, `PSS_FLAG_ADDR, 0);
    chk({31'h0, rdat[b]}, 32'h1, "flag");
    if (k == 200) stop_test();
  endtask

  initial forever #2.5 pclk = ~pclk;
  initial begin
    repeat (100000) @(posedge pclk);
    n_fail++;
    stop_test();
  end

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({24'h0, oe, sw}, 32'h0, "pins after reset");
    apb(0, `PSS_SHDN_ADDR, 0);
    chk(rdat, 32'h0, "shutdown reset");
    apb(0, `PSS_PERIOD_ADDR, 0);
    chk(rdat, 32'hff, "period reset");
    apb(0, 12'h014, 0);
    chk(rdat, 32'h100, "unmapped");
    apb(1, `PSS_SHDN_ADDR, 32'h4);
    apb(1, `PSS_PERIOD_ADDR, 32'h0f);
    apb(1, `PSS_CTRL_ADDR, 32'h04);
    wait_bit(2);
    chk({28'h0, oe}, 32'h0, "before drivers");
    chk({31'h0, rdat[0]}, 32'h1, "period flag");
    chk({30'h0, flag2, flag1}, 32'h1, "flag pins");
    for (i = 0; i < 4; i++) begin
      apb(1, `PSS_CTRL_ADDR, 32'h4 | i);
      apb(1, `PSS_CTRL_ADDR, 32'hc | i);
      repeat (2) @(posedge pclk);
      chk({oe, sw}, {4'hf, ~i[1], i[0], ~i[1], i[0]}, "polarity");
    end
    apb(1, `PSS_CTRL_ADDR, 32'h4);
    apb(1, `PSS_CTRL_ADDR, 32'h1c);
    rdat = 32'h0;
    wait_bit(1);
    apb(1, `PSS_FLAG_ADDR, 32'h1);
    @(posedge pclk);
    chk({30'h0, flag2, flag1}, 32'h2, "flag clear");
    for (i = 0; i < 3; i++) begin
      apb(1, `PSS_SHDN_ADDR, (32'h10 << i) | 32'h4);
      src(~(3'h1 << i));
      apb(0, `PSS_SHDN_ADDR, 0);
      chk({31'h0, rdat[7]}, 32'h0, "unselected");
      src(3'h1 << i);
      repeat (2) @(posedge pclk);
      chk({oe, sw}, 8'hfa, "shutdown pins");
      src(3'h0);
      apb(0, `PSS_SHDN_ADDR, 0);
      chk({31'h0, rdat[7]}, 32'h1, "status held");
      apb(1, `PSS_SHDN_ADDR, 32'h0);
      apb(0, `PSS_SHDN_ADDR, 0);
      chk(rdat, 32'h0, "status cleared");
    end
    apb(1, `PSS_SHDN_ADDR, 32'h8a);
    repeat (2) @(posedge pclk);
    chk({28'h0, oe}, 32'h0, "firmware shutdown");
    apb(1, `PSS_SHDN_ADDR, 32'h0);
    repeat (2) @(posedge pclk);
    chk({28'h0, oe}, 32'hf, "restart");
    stop_test();
  end
endmodule // tb_pwm_startup_auto_shutdown

`default_nettype wire
